// ### logic/ep0_csr.sv
// endpoint zero control/status register with its serial interface engine events
`timescale 1ns/1ns
module ep0_csr (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire ep0_csr_pkg::reg_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire ep0_csr_pkg::sie_evt_s SIE_EVT,
  output ep0_csr_pkg::sie_ctl_s SIE_CTL,
  output logic EP0_INT
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] wd;

  // the block answers only while the endpoint index selects endpoint zero
  assign hit = (REG_REQ.addr == ep0_csr_pkg::CSR_ADDR) && (REG_REQ.index == ep0_csr_pkg::CSR_INDEX);
  assign wr_hit = REG_REQ.wr && hit;
  assign rd_hit = REG_REQ.rd && hit;
  assign wd = REG_REQ.wdata;

  logic svc_setup_end;
  logic svc_pkt;
  logic set_stall;
  logic setup_end_event;

  assign svc_setup_end = wr_hit && wd[ep0_csr_pkg::SERVICED_SETUP_END_BIT];
  assign svc_pkt = wr_hit && wd[ep0_csr_pkg::SERVICED_PACKET_RECEIVED_BIT];
  assign set_stall = wr_hit && wd[ep0_csr_pkg::SEND_STALL_BIT];

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic setup_end_flag_q;
  logic packet_received_flag_q;
  logic send_stall_q;
  logic sent_stall_flag_q;
  logic in_packet_ready_q;
  logic transfer_last_packet_q;

  // a transfer that ends after the last-packet bit was set is a normal end
  assign setup_end_event = SIE_EVT.ctrl_end_early && !transfer_last_packet_q;

  // set wins over the serviced clear so a back-to-back event is not lost
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      setup_end_flag_q <= 1'b0;
    end else if (setup_end_event) begin
      setup_end_flag_q <= 1'b1;
    end else if (svc_setup_end) begin
      setup_end_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      packet_received_flag_q <= 1'b0;
    end else if (SIE_EVT.pkt_loaded) begin
      packet_received_flag_q <= 1'b1;
    end else if (svc_pkt) begin
      packet_received_flag_q <= 1'b0;
    end
  end

  // a fresh abort request from firmware outranks the completion of an older stall
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      send_stall_q <= 1'b0;
    end else if (set_stall) begin
      send_stall_q <= 1'b1;
    end else if (SIE_EVT.stall_sent) begin
      send_stall_q <= 1'b0;
    end
  end

  // sent-stall is cleared by firmware writing zero to it
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sent_stall_flag_q <= 1'b0;
    end else if (SIE_EVT.stall_sent) begin
      sent_stall_flag_q <= 1'b1;
    end else if (wr_hit && !wd[ep0_csr_pkg::SENT_STALL_FLAG_BIT]) begin
      sent_stall_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      in_packet_ready_q <= 1'b0;
    end else if (wr_hit && wd[ep0_csr_pkg::IN_PACKET_READY_BIT]) begin
      in_packet_ready_q <= 1'b1;
    end else if (SIE_EVT.in_sent) begin
      in_packet_ready_q <= 1'b0;
    end
  end

  // last-packet marker lives until the transfer it belongs to is over
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      transfer_last_packet_q <= 1'b0;
    end else if (wr_hit && wd[ep0_csr_pkg::TRANSFER_LAST_PACKET_BIT]) begin
      transfer_last_packet_q <= 1'b1;
    end else if (SIE_EVT.status_done || SIE_EVT.ctrl_end_early) begin
      transfer_last_packet_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request and read data
  // ----------------------------------------------------------------
  logic [7:0] csr_view;

  // serviced bits are write-only commands and always read as zero
  assign csr_view = {1'b0, 1'b0, send_stall_q, setup_end_flag_q, transfer_last_packet_q,
                     sent_stall_flag_q, in_packet_ready_q, packet_received_flag_q};

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      EP0_INT <= 1'b0;
    end else begin
      EP0_INT <= SIE_EVT.pkt_loaded || SIE_EVT.in_sent || SIE_EVT.stall_sent
                 || setup_end_event || SIE_EVT.status_done;
    end
  end

  // read data is captured on the read strobe and held until the next read
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      REG_RDATA <= ep0_csr_pkg::CSR_RESET;
    end else if (rd_hit) begin
      REG_RDATA <= csr_view;
    end else if (REG_REQ.rd) begin
      REG_RDATA <= 8'h00;
    end
  end

  assign SIE_CTL.send_stall = send_stall_q;
  assign SIE_CTL.transfer_last_packet = transfer_last_packet_q;
  assign SIE_CTL.in_packet_ready = in_packet_ready_q;
  assign SIE_CTL.packet_received_flag = packet_received_flag_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_rd_addr_map: assert property (@(posedge MCLK) disable iff (SYS_RST)
    rd_hit |=> REG_RDATA == {2'b00, $past(send_stall_q), $past(setup_end_flag_q),
      $past(transfer_last_packet_q), $past(sent_stall_flag_q), $past(in_packet_ready_q),
      $past(packet_received_flag_q)})
    else $error("register read does not match flag layout");

  chk_svc_setup_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    svc_setup_end && !setup_end_event |=> !setup_end_flag_q && REG_RDATA[7] == 1'b0)
    else $error("serviced setup end did not clear setup end flag");

  chk_svc_pkt_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    svc_pkt && !SIE_EVT.pkt_loaded |=> !packet_received_flag_q ##1 REG_RDATA[6] == 1'b0)
    else $error("serviced packet did not clear packet received flag");

  chk_stall_self_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.stall_sent && !set_stall |=> !SIE_CTL.send_stall)
    else $error("send stall still set after stall sent");

  chk_setup_end_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.ctrl_end_early && !transfer_last_packet_q |=> setup_end_flag_q ##1 (setup_end_flag_q || $past(svc_setup_end)))
    else $error("setup end flag not set or dropped without service");

  chk_pkt_irq: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.pkt_loaded |=> EP0_INT && SIE_CTL.packet_received_flag)
    else $error("loaded packet did not set flag and interrupt");

  chk_in_sent: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.in_sent && !(wr_hit && wd[ep0_csr_pkg::IN_PACKET_READY_BIT]) |=> EP0_INT && !SIE_CTL.in_packet_ready)
    else $error("sent in packet did not clear ready and interrupt");

  chk_sent_stall: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.stall_sent |=> EP0_INT && sent_stall_flag_q)
    else $error("sent stall did not set flag and interrupt");

  chk_zero_write_keep: assert property (@(posedge MCLK) disable iff (SYS_RST)
    wr_hit && wd[7:5] == 3'b000 && !SIE_EVT.stall_sent && !setup_end_event && !SIE_EVT.pkt_loaded
    |=> $stable(setup_end_flag_q) && $stable(packet_received_flag_q) && $stable(send_stall_q))
    else $error("zero write to command bits changed a flag");

  chk_svc_read_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
    rd_hit |=> REG_RDATA[7:6] == 2'h0)
    else $error("serviced bits did not read as zero");

  chk_unmapped_read: assert property (@(posedge MCLK) disable iff (SYS_RST)
    REG_REQ.rd && !hit |=> REG_RDATA == 8'h00)
    else $error("read outside endpoint zero register returned data");

  chk_set_beats_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.pkt_loaded && svc_pkt |=> packet_received_flag_q)
    else $error("packet received flag lost to a same-cycle service write");

  chk_early_end_normal: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SIE_EVT.ctrl_end_early && transfer_last_packet_q && !svc_setup_end |=> $stable(setup_end_flag_q))
    else $error("normal transfer end changed setup end flag");

  chk_int_quiet: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !SIE_EVT.pkt_loaded && !SIE_EVT.in_sent && !SIE_EVT.stall_sent && !setup_end_event
    && !SIE_EVT.status_done |=> !EP0_INT)
    else $error("interrupt raised without an event");

endmodule

// ### inc/ep0_csr_pkg.sv
// package: register map, field positions and carriers for the endpoint zero control/status block
package ep0_csr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_ADDR = 8'h11;
  localparam logic [3:0] CSR_INDEX = 4'h0;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions, bit 7 down to bit 0
  // ----------------------------------------------------------------
  localparam int unsigned SERVICED_SETUP_END_BIT = 7;
  localparam int unsigned SERVICED_PACKET_RECEIVED_BIT = 6;
  localparam int unsigned SEND_STALL_BIT = 5;
  localparam int unsigned SETUP_END_FLAG_BIT = 4;
  localparam int unsigned TRANSFER_LAST_PACKET_BIT = 3;
  localparam int unsigned SENT_STALL_FLAG_BIT = 2;
  localparam int unsigned IN_PACKET_READY_BIT = 1;
  localparam int unsigned PACKET_RECEIVED_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] index;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // one-cycle event pulses from the serial interface engine
  typedef struct packed {
    logic pkt_loaded;
    logic in_sent;
    logic stall_sent;
    logic ctrl_end_early;
    logic status_done;
  } sie_evt_s;

  // levels presented back to the serial interface engine
  typedef struct packed {
    logic send_stall;
    logic transfer_last_packet;
    logic in_packet_ready;
    logic packet_received_flag;
  } sie_ctl_s;

endpackage

// ### sim/sie_host_model.sv
// host-side stand-in that raises serial engine events
`timescale 1ns/1ns
module sie_host_model (
  input wire ep0_csr_pkg::sie_ctl_s CTL,
  output ep0_csr_pkg::sie_evt_s EVT
);
  initial begin
    EVT = '0;
  end
  // kinds 1..5: loaded, in sent, stall sent, early end, status done
  // an in or stall event with nothing armed cannot occur on the link, so it is dropped
  task automatic put(input int k, output int done);
    done = k;
    if (k == 2 && CTL.in_packet_ready !== 1'b1) begin
      done = 0;
    end
    if (k == 3 && CTL.send_stall !== 1'b1) begin
      done = 0;
    end
    EVT = (done == 0) ? '0 : ep0_csr_pkg::sie_evt_s'(5'h10 >> (done - 1));
  endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the endpoint zero control/status block
`timescale 1ns/1ns
module tb;
  logic mclk;
  logic sys_rst;
  ep0_csr_pkg::reg_req_s reg_req;
  logic [7:0] reg_rdata;
  ep0_csr_pkg::sie_evt_s sie_evt;
  ep0_csr_pkg::sie_ctl_s sie_ctl;
  logic ep0_int;
  logic [7:0] m;
  logic [7:0] exp_rd;
  logic exp_int;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  ep0_csr u_ep0_csr (.MCLK(mclk), .SYS_RST(sys_rst), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
    .SIE_EVT(sie_evt), .SIE_CTL(sie_ctl), .EP0_INT(ep0_int));
  sie_host_model u_sie_host_model (.CTL(sie_ctl), .EVT(sie_evt));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // a hang stops the run well past the planned length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_ctl(input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH control levels expected %h seen %h", exp, got);
    end
  endtask
  task automatic cmp_int(input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH interrupt expected %h seen %h", exp, got);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH read data expected %h seen %h", exp, got);
    end
  endtask
  // --------------------------------------------------------
  // one cycle: drive at a falling edge, model and compare at the next
  // --------------------------------------------------------
  task automatic cyc(input logic w, input logic r, input logic [3:0] ix, input logic [7:0] a,
      input logic [7:0] d, input int ev);
    logic hit;
    int got;
    hit = (ix == ep0_csr_pkg::CSR_INDEX) && (a == ep0_csr_pkg::CSR_ADDR);
    reg_req = '{wr: w, rd: r, index: ix, addr: a, wdata: d};
    u_sie_host_model.put(ev, got);
    @(negedge mclk);
    if (r) begin
      exp_rd = hit ? {2'b00, m[5:0]} : 8'h00;
    end
    exp_int = 1'b0;
    if (w && hit) begin
      m[4] = d[7] ? 1'b0 : m[4];
      m[0] = d[6] ? 1'b0 : m[0];
      m[5] = m[5] | d[5];
      m[3] = m[3] | d[3];
      m[2] = m[2] & d[2];
      m[1] = m[1] | d[1];
    end
    case (got)
      1: {m[0], exp_int} = 2'h3;
      2: {m[1], exp_int} = 2'h1;
      3: {m[5], m[2], exp_int} = 3'h3;
      4: {m[4], m[3], exp_int} = {m[4] | ~m[3], 1'b0, ~m[3]};
      5: {m[3], exp_int} = 2'h1;
      default: ;
    endcase
    cmp_ctl({m[5], m[3], m[1], m[0]}, sie_ctl);
    cmp_int(exp_int, ep0_int);
    cmp_rd(exp_rd, reg_rdata);
  endtask
  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    void'($urandom(91));
    sys_rst = 1'b1;
    reg_req = '0;
    m = 8'h00;
    exp_rd = 8'h00;
    exp_int = 1'b0;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    cyc(0, 0, 4'h0, 8'h11, 8'h00, 0);
    cyc(0, 1, 4'h0, 8'h11, 8'h00, 0);
    cyc(1, 0, 4'h0, 8'h11, 8'h2A, 0);
    cyc(0, 1, 4'h0, 8'h11, 8'h00, 3);
    cyc(0, 0, 4'h0, 8'h11, 8'h00, 4);
    cyc(0, 1, 4'h0, 8'h11, 8'h00, 4);
    cyc(0, 0, 4'h0, 8'h11, 8'h00, 1);
    cyc(1, 1, 4'h1, 8'h11, 8'hC0, 0);
    cyc(1, 1, 4'h0, 8'h11, 8'h04, 0);
    cyc(1, 1, 4'h0, 8'h11, 8'hC4, 0);
    cyc(1, 0, 4'h0, 8'h11, 8'h40, 1);
    cyc(0, 1, 4'h0, 8'h11, 8'h00, 2);
    // writes and events never share a cycle, so priorities stay out of the model
    for (int i = 0; i < 3000; i++) begin
      k = $urandom_range(0, 3);
      cyc(k == 1, 1'($urandom_range(0, 1)), ($urandom_range(0, 7) == 0) ? 4'h1 : 4'h0,
        ($urandom_range(0, 7) == 0) ? 8'h12 : 8'h11, 8'($urandom()),
        (k == 2) ? $urandom_range(1, 5) : 0);
    end
    end_of_test();
  end
endmodule
